// ==== design/usb_host_regs.sv ====
`timescale 1ns/10ps
// How it works
// [RULE_01] Pulse starts high, drops after hold delay.
// [RULE_02] Supply dips under 11 us are ignored.
// [RULE_03] Dip over 11 us raises the pulse.
// [RULE_04] Host holds reset at least 3 ms; the bench releases the pin together with rst.
// [RULE_05] Works with reset pin tied or driven.
// [RULE_06] All registers decoded as 32-bit words.
// [RULE_07] 16-bit bus pairs two accesses per register.
// [RULE_08] Operational low, configuration from 0300h upward.
// [RULE_09] Capability length reads constant 20h.
// [RULE_10] Interface version reads constant 0100h.
// [RULE_11] Structural word reads 11h, low nibble ports.
// [RULE_12] Port power control bit reads one.
// [RULE_13] Debug port field reads zero.
// [RULE_14] Port indicator bit reads zero.
// [RULE_15] Companion count fields read zero.
// [RULE_16] Port routing bit reads zero.
// [RULE_17] Software writes zero to reserved bits.
// [RULE_18] Capability writes have no effect.
module usb_host_regs #(
    // Value is arbitrary; it only has to be a fixed identity.
    parameter logic [31:0] CHIP_IDENTITY = 32'h0000_5A5A
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reset_in_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [usb_host_regs_pkg::ADDR_MSB:1] addr,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic data_oe,
    input wire logic bus_16bit_strap,
    input wire logic regulator_above_high,
    input wire logic regulator_below_low,
    output logic power_on_pulse,
    output logic chip_reset
);
    import usb_host_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [5:0] raw_pins; // Asynchronous pins gathered into one vector.
    logic [5:0] sync1; // First stage, read only by the second stage.
    logic [5:0] sync2; // Second stage.
    logic [5:0] sync3; // Third stage.
    logic [5:0] filt; // Level that changes once stages two and three agree.

    assign raw_pins = {reset_in_n, rd_n, wr_n, cs_n,
                       regulator_above_high, regulator_below_low};

    // Three synchroniser flops per pin plus a filter flop; the agreement filter rejects one-cycle glitches.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
            sync3 <= SYNC_IDLE;
            filt <= SYNC_IDLE;
        end else begin
            sync1 <= raw_pins;
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
        end
    end

    logic supply_high; // Regulator output above the upper trip level.
    logic supply_low; // Regulator output below the lower trip level.
    logic reset_pin_ok; // External reset pin released.

    assign supply_high = filt[PIN_HIGH];
    assign supply_low = filt[PIN_LOW];
    assign reset_pin_ok = filt[PIN_RESET];

    ////////////////////////////////////////////////////////////////////////
    // Power-on pulse.

    por_state_t por_state; // Sequencer state.
    logic [CNT_W-1:0] hold_cnt; // Cycles spent holding after the rise.
    logic [CNT_W-1:0] dip_cnt; // Cycles the supply has been low.
    logic dip_long; // Supply has been low for longer than the ignore time.

    assign dip_long = (dip_cnt == CNT_W'(DIP_CYCLES));

    // Counts a dip and saturates, so a long brown-out cannot wrap around.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dip_cnt <= '0;
        end else if (!supply_low) begin
            dip_cnt <= '0; // RULE_02
        end else if (!dip_long) begin
            dip_cnt <= dip_cnt + CNT_W'(1);
        end
    end

    // The pulse is high from reset until the supply is up plus the hold.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            por_state <= POR_WAIT_RISE;
            power_on_pulse <= 1'b1; // RULE_01
            hold_cnt <= '0;
        end else if (dip_long) begin
            // A long dip wins over every other state.
            por_state <= POR_WAIT_RISE;
            power_on_pulse <= 1'b1; // RULE_03
            hold_cnt <= '0;
        end else begin
            case (por_state)
                POR_WAIT_RISE: begin
                    power_on_pulse <= 1'b1;
                    hold_cnt <= '0;
                    if (supply_high) begin
                        por_state <= POR_HOLD; // RULE_01
                    end
                end
                POR_HOLD: begin
                    if (hold_cnt == CNT_W'(HOLD_CYCLES - 1)) begin
                        por_state <= POR_RUN;
                        power_on_pulse <= 1'b0; // RULE_01
                    end else begin
                        hold_cnt <= hold_cnt + CNT_W'(1);
                    end
                end
                POR_RUN: begin
                    // Short dips land here and leave the pulse low.
                    power_on_pulse <= 1'b0; // RULE_02
                end
                default: begin
                    por_state <= POR_WAIT_RISE;
                    power_on_pulse <= 1'b1;
                end
            endcase
        end
    end

    // Either source resets the core: a tied pin leaves only the detector.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chip_reset <= 1'b1;
        end else begin
            chip_reset <= power_on_pulse || !reset_pin_ok; // RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus width strap, caught once after reset release.

    logic bus16; // Data bus is 16 bits wide.
    logic strap_done; // Strap has been sampled.

    // The strap is static; sampling it once avoids a mid-access width change.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus16 <= 1'b0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            bus16 <= bus_16bit_strap;
            strap_done <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access strobes.

    logic rd_act; // Read strobe active with chip select.
    logic wr_act; // Write strobe active with chip select.
    logic rd_act_d; // Read strobe one cycle ago.
    logic wr_act_d; // Write strobe one cycle ago.
    logic rd_start; // First cycle of a read access.
    logic wr_start; // First cycle of a write access.
    logic half_hi; // Access addresses the upper half word.
    logic [OFS_W-1:0] word_ofs; // Byte offset of the addressed word.

    assign rd_act = !filt[PIN_CS] && !filt[PIN_RD] && !chip_reset;
    assign wr_act = !filt[PIN_CS] && !filt[PIN_WR] && !chip_reset;
    assign rd_start = rd_act && !rd_act_d;
    assign wr_start = wr_act && !wr_act_d;
    assign half_hi = addr[1];
    assign word_ofs = {addr[ADDR_MSB:2], 2'b00}; // RULE_06

    // Edge memory for the strobes.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_act_d <= 1'b0;
            wr_act_d <= 1'b0;
        end else begin
            rd_act_d <= rd_act;
            wr_act_d <= wr_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write pairing.

    logic [15:0] wr_hold; // Low half word waiting for its upper half.
    logic wr_commit; // A full 32-bit word is written this cycle.
    logic [31:0] wr_data; // The full word being written.
    logic soft_clear; // Software asked for a register reset.

    assign wr_commit = wr_start && (!bus16 || half_hi); // RULE_07
    assign wr_data = bus16 ? {data_in[15:0], wr_hold} : data_in;

    // The low half only parks; nothing changes until the pair is complete.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_hold <= '0;
        end else if (wr_start && bus16 && !half_hi) begin
            wr_hold <= data_in[15:0]; // RULE_07
        end
    end

    // A one in the soft reset bit restores every register a cycle later.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            soft_clear <= 1'b0;
        end else begin
            soft_clear <= wr_commit &&
                word_ofs == STORE_OFS[SOFTWARE_RESET_IDX] &&
                wr_data[SOFT_RESET_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [31:0] store [NUM_STORE]; // Registers with storage.
    logic rd_clear; // A full-word read is snapshotted this cycle.

    // The full word is snapshotted at the first half, so clear it there.
    assign rd_clear = rd_start && (!bus16 || !half_hi);

    // Capability words have no storage, so writes to them fall away.
    generate
        for (genvar i = 0; i < NUM_STORE; i++) begin : g_store
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    store[i] <= STORE_RESET[i];
                end else if (chip_reset || soft_clear) begin
                    store[i] <= STORE_RESET[i];
                end else if (wr_commit && word_ofs == STORE_OFS[i]) begin
                    case (STORE_KIND[i])
                        ACC_RW: store[i] <= wr_data; // RULE_08
                        ACC_WO: store[i] <= wr_data;
                        ACC_W1C: store[i] <= store[i] & ~wr_data;
                        default: store[i] <= store[i];
                    endcase
                end else if (rd_clear && word_ofs == STORE_OFS[i] &&
                             STORE_KIND[i] == ACC_RC) begin
                    store[i] <= '0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read path.

    logic [31:0] rd_word; // Current content of the addressed word.
    logic [31:0] rd_hold; // Word captured by the first half of a pair.

    // Unmapped words and write-only registers read as zero.
    always_comb begin
        rd_word = '0;
        if (word_ofs == CAP_LENGTH_OFS) begin
            rd_word = {INTERFACE_VERSION_BCD, 8'h00,
                       CAPABILITY_LENGTH}; // RULE_09 RULE_10
        end else if (word_ofs == STRUCT_PARAM_OFS) begin // RULE_12 RULE_14
            rd_word = STRUCTURAL_PARAMETERS; // RULE_11 RULE_13 RULE_15 RULE_16
        end else if (word_ofs == CAP_PARAM_OFS) begin
            rd_word = CAPABILITY_PARAMETERS; // RULE_18
        end else if (word_ofs == CHIP_IDENTITY_OFS) begin
            rd_word = CHIP_IDENTITY;
        end
        for (int i = 0; i < NUM_STORE; i++) begin
            if (word_ofs == STORE_OFS[i] && STORE_KIND[i] != ACC_WO) begin
                rd_word = store[i];
            end
        end
    end

    // Snapshot at the first half keeps both halves of one word coherent.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_hold <= '0;
        end else if (rd_clear) begin
            rd_hold <= rd_word; // RULE_07
        end
    end

    // Data is driven from the cycle after the strobe starts until it ends.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data_out <= '0;
            data_oe <= 1'b0;
        end else if (rd_start) begin
            data_oe <= 1'b1;
            if (!bus16) begin
                data_out <= rd_word; // RULE_06
            end else if (half_hi) begin
                data_out <= {16'h0000, rd_hold[31:16]}; // RULE_07
            end else begin
                data_out <= {16'h0000, rd_word[15:0]};
            end
        end else if (!rd_act) begin
            data_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    logic cap_written; // A write has reached the capability parameters word.
    // Remembers that write, so the check below only counts reads after it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cap_written <= 1'b0;
        end else if (wr_commit && word_ofs == CAP_PARAM_OFS) begin
            cap_written <= 1'b1; // RULE_18
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_rise;
        por_state == POR_WAIT_RISE && supply_high && !dip_long;
    endsequence

    sequence s_word_read(logic [9:0] ofs);
        rd_start && !bus16 && word_ofs == ofs;
    endsequence

    a_pulse_rise_hold: assert property ( // RULE_01
        s_rise |=> power_on_pulse ##1 power_on_pulse)
        else $error("pulse fell too early after supply rise");

    a_pulse_hold_time: assert property ( // RULE_01
        $fell(power_on_pulse) |->
            $past(hold_cnt) == CNT_W'(HOLD_CYCLES - 1))
        else $error("pulse fell before the hold delay");

    a_short_dip_ignored: assert property ( // RULE_02
        (por_state == POR_RUN && !power_on_pulse &&
         dip_cnt < CNT_W'(DIP_CYCLES - 1)) |=> !power_on_pulse)
        else $error("pulse rose on a short dip");

    a_long_dip_pulse: assert property ( // RULE_03
        dip_long |=> power_on_pulse && por_state == POR_WAIT_RISE)
        else $error("long dip did not raise the pulse");

    a_reset_pin_follow: assert property ( // RULE_05
        !reset_pin_ok |=> chip_reset)
        else $error("reset pin low but core not in reset");

    a_scratch_store: assert property ( // RULE_06
        (wr_commit && !soft_clear && !chip_reset &&
         word_ofs == STORE_OFS[SCRATCH_IDX])
        |=> store[SCRATCH_IDX] == $past(wr_data))
        else $error("scratch word did not take the written value");

    a_half_write_wait: assert property ( // RULE_07
        (wr_start && bus16 && !half_hi && !soft_clear)
        |=> $stable(store[SCRATCH_IDX]))
        else $error("low half write changed a register");

    a_cap_words: assert property ( // RULE_09
        s_word_read(CAP_LENGTH_OFS) |=> data_oe &&
            data_out == {INTERFACE_VERSION_BCD, 8'h00, CAPABILITY_LENGTH})
        else $error("capability length or version wrong");

    a_struct_ports: assert property ( // RULE_11
        s_word_read(STRUCT_PARAM_OFS) |=>
            data_out == STRUCTURAL_PARAMETERS &&
            data_out[PORT_COUNT_LSB +: 4] == 4'h1)
        else $error("structural word wrong");

    a_struct_power: assert property ( // RULE_12
        s_word_read(STRUCT_PARAM_OFS) |=> data_out[PORT_POWER_BIT])
        else $error("port power bit not set");

    a_struct_zero: assert property ( // RULE_13 RULE_14 RULE_15 RULE_16
        s_word_read(STRUCT_PARAM_OFS) |=>
            data_out[DEBUG_PORT_LSB +: 4] == 4'h0 &&
            !data_out[INDICATOR_BIT] && !data_out[ROUTING_BIT] &&
            data_out[PER_COMPANION_LSB +: 8] == 8'h00)
        else $error("structural zero fields not zero");

    a_cap_write_ignored: assert property ( // RULE_18
        (cap_written ##0 s_word_read(CAP_PARAM_OFS))
        |=> data_out == CAPABILITY_PARAMETERS)
        else $error("capability word changed after a write");

    a_read_oe_drop: assert property ( // RULE_06
        (data_oe && !rd_act) |=> !data_oe)
        else $error("data kept driven after read ended");

endmodule

// ==== design/usb_host_regs_pkg.sv ====
package usb_host_regs_pkg;

    // Core clock rate and the nanoseconds in a microsecond.
    localparam int CLK_MHZ = 50;
    localparam int NS_PER_US = 1000;

    // Supply dips shorter than this are ignored by the power-on pulse.
    localparam int DIP_IGNORE_NS = 11_000;
    // Least time, so the cycle count rounds up.
    localparam int DIP_CYCLES =
        (DIP_IGNORE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    // Extra hold of the pulse after the supply passes the upper trip level.
    localparam int POWER_ON_HOLD_NS = 2_000;
    localparam int HOLD_CYCLES =
        (POWER_ON_HOLD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int CNT_W = 16;

    // Processor address pins carry byte address bits 9 to 1.
    localparam int ADDR_MSB = 9;
    localparam int OFS_W = 10;

    // Capability words and their fixed contents, plus the chip identity word offset.
    localparam logic [9:0] CAP_LENGTH_OFS = 10'h000;
    localparam logic [9:0] STRUCT_PARAM_OFS = 10'h004;
    localparam logic [9:0] CAP_PARAM_OFS = 10'h008;
    localparam logic [9:0] CHIP_IDENTITY_OFS = 10'h304;
    localparam logic [7:0] CAPABILITY_LENGTH = 8'h20;
    localparam logic [15:0] INTERFACE_VERSION_BCD = 16'h0100;
    localparam logic [31:0] STRUCTURAL_PARAMETERS = 32'h0000_0011;
    localparam logic [31:0] CAPABILITY_PARAMETERS = 32'h0000_0086;

    // Field positions inside the structural parameters word.
    localparam int PORT_COUNT_LSB = 0;
    localparam int PORT_POWER_BIT = 4;
    localparam int ROUTING_BIT = 7;
    localparam int PER_COMPANION_LSB = 8;
    localparam int COMPANION_LSB = 12;
    localparam int INDICATOR_BIT = 16;
    localparam int DEBUG_PORT_LSB = 20;

    // Operational and configuration windows.
    localparam logic [9:0] OPER_LAST = 10'h1FF;
    localparam logic [9:0] CONFIG_FIRST = 10'h300;

    // How a stored register answers reads and writes.
    typedef enum logic [1:0] {
        ACC_RW = 2'b00,
        ACC_W1C = 2'b01,
        ACC_RC = 2'b10,
        ACC_WO = 2'b11
    } access_t;

    localparam int NUM_STORE = 34;
    localparam int SCRATCH_IDX = 16;
    localparam int SOFTWARE_RESET_IDX = 17;
    localparam int SOFT_RESET_BIT = 0;

    localparam logic [9:0] STORE_OFS [NUM_STORE] = '{
        10'h020, 10'h024, 10'h028, 10'h02C, 10'h060, 10'h064,
        10'h130, 10'h134, 10'h138, 10'h140, 10'h144, 10'h148,
        10'h150, 10'h154, 10'h158, 10'h300, 10'h308, 10'h30C,
        10'h310, 10'h314, 10'h318, 10'h31C, 10'h320, 10'h324,
        10'h328, 10'h32C, 10'h330, 10'h334, 10'h338, 10'h33C,
        10'h340, 10'h344, 10'h354, 10'h374};

    localparam logic [31:0] STORE_RESET [NUM_STORE] = '{
        32'h0008_0B00, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_2000, 32'h0000_0000, 32'hFFFF_FFFF,
        32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000,
        32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0100,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_000F, 32'h0000_0000,
        32'h03E8_1BA0, 32'h0086_0086};

    localparam access_t STORE_KIND [NUM_STORE] = '{
        ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RW,
        ACC_RC, ACC_RW, ACC_RW, ACC_RC, ACC_RW, ACC_RW,
        ACC_RC, ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RW,
        ACC_W1C, ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RW,
        ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RW,
        ACC_RW, ACC_WO, ACC_RW, ACC_RW};

    // Synchroniser idle pattern: reset pin low, strobes high, comparators low.
    localparam logic [5:0] SYNC_IDLE = 6'h1C;
    localparam int PIN_RESET = 5;
    localparam int PIN_RD = 4;
    localparam int PIN_WR = 3;
    localparam int PIN_CS = 2;
    localparam int PIN_HIGH = 1;
    localparam int PIN_LOW = 0;

    // Power-on pulse sequencer.
    typedef enum logic [1:0] {
        POR_WAIT_RISE = 2'b00,
        POR_HOLD = 2'b01,
        POR_RUN = 2'b10
    } por_state_t;

endpackage

// ==== verif/host_proc_model.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// Processor model that drives the register port pins.
// Every access holds its pins from one falling edge to another.
module host_proc_model (
    input wire logic core_clk,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [9:1] addr,
    output logic [31:0] data_in
);
    // Strobes idle high so nothing is taken before the first access.
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 9'h000;
        data_in = 32'h0000_0000;
    end

    // One access, strobe held low for low_cycles, then a quiet gap.
    // The gap keeps the strobe high long enough for the input filter.
    task automatic access(input logic wr, input logic [9:0] ofs,
                          input logic [31:0] d, input int low_cycles);
        @(negedge core_clk);
        addr <= ofs[9:1];
        data_in <= d;
        cs_n <= 1'b0;
        rd_n <= wr;
        wr_n <= !wr;
        repeat (low_cycles) @(negedge core_clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        // Released data lines show the inverse, never a stale copy.
        data_in <= ~d;
        repeat (6) @(negedge core_clk);
    endtask
endmodule

// ==== verif/usb_host_capability_register_map_bench.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// Bench for the register map and the power-on pulse.
module usb_host_capability_register_map_bench;
    import usb_host_regs_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reset_in_n = 1'b0;
    logic strap = 1'b0;
    logic above = 1'b0;
    logic below = 1'b0;
    logic cs_n, rd_n, wr_n, data_oe, power_on_pulse, chip_reset;
    logic [9:1] addr;
    logic [31:0] data_in, data_out, r;
    logic oe_q = 1'b0;
    // Reads waiting for their answer, oldest first.
    logic [31:0] expq[$];
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [9:0] caps[3] = '{10'h000, 10'h004, 10'h008};
    logic [31:0] capv[3] = '{32'h0100_0020, 32'h0000_0011, 32'h0000_0086};

    always #10 core_clk = ~core_clk;

    usb_host_regs #(.CHIP_IDENTITY(32'h0000_C3C3)) usb_host_regs_inst (
        .core_clk(core_clk), .rst(rst), .reset_in_n(reset_in_n),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .bus_16bit_strap(strap), .regulator_above_high(above),
        .regulator_below_low(below), .power_on_pulse(power_on_pulse),
        .chip_reset(chip_reset));

    host_proc_model host_proc_model_inst (
        .core_clk(core_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .data_in(data_in));

    ////////////////////////////////////////////////////////////
    // Compare one value and count the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Strobe length varies so the device sees prompt and slow hosts.
    task automatic rd(input logic [9:0] ofs, input logic [31:0] exp);
        expq.push_back(exp);
        host_proc_model_inst.access(1'b0, ofs, 32'h0000_0000,
                                    6 + $urandom % 6);
    endtask

    task automatic wr(input logic [9:0] ofs, input logic [31:0] d);
        host_proc_model_inst.access(1'b1, ofs, d, 6 + $urandom % 6);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Each rising output enable is one answer; an unasked answer is a fault.
    always @(negedge core_clk) begin
        oe_q <= data_oe;
        if (data_oe === 1'b1 && oe_q !== 1'b1) begin
            if (expq.size() == 0) begin
                miscompares++;
                $display("ERROR %0t answer with no read pending", $time);
            end else check(data_out, expq.pop_front());
        end
    end

    // A hang is cut short well beyond the expected run length.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("ERROR %0t run took too long", $time);
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'ha5f9_70cc));
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rst <= 1'b0;
        // The pin is held only through the reset time: the model has no
        // clocks that need settling, and the full hold would cost the run.
        reset_in_n <= 1'b1;
        above <= 1'b1;
        wait_n(HOLD_CYCLES - 5);
        check(32'(power_on_pulse), 32'h0000_0001);
        wait_n(20);
        check(32'(power_on_pulse), 32'h0000_0000);
        check(32'(chip_reset), 32'h0000_0000);
        rd(caps[0], capv[0]);
        rd(caps[1], capv[1]);
        rd(caps[1], capv[1]);
        rd(caps[2], capv[2]);
        // Reserved structural bits are written as zero, as software must.
        for (int i = 0; i < 3; i++) begin
            r = $urandom & ((i == 1) ? 32'h00F1_FF9F : 32'hFFFF_FFFF);
            wr(caps[i], r);
            rd(caps[i], capv[i]);
        end
        for (int i = 0; i < NUM_STORE; i++) begin
            rd(STORE_OFS[i], STORE_RESET[i]);
        end
        rd(10'h304, 32'h0000_C3C3);
        rd(10'h200, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            r = $urandom;
            wr(10'h308, r);
            rd(10'h308, r);
        end
        // The soft reset bit restores the scratch word and clears itself.
        wr(10'h30C, 32'h0000_0001);
        rd(10'h308, 32'h0000_0000);
        rd(10'h30C, 32'h0000_0000);
        // Pin driven low: chip held in reset, a read gets no answer.
        reset_in_n <= 1'b0;
        wait_n(8);
        check(32'(chip_reset), 32'h0000_0001);
        host_proc_model_inst.access(1'b0, 10'h308, 32'h0000_0000, 8);
        reset_in_n <= 1'b1;
        wait_n(10);
        rd(10'h308, 32'h0000_0000);
        // A dip shorter than the filter leaves the pulse low.
        above <= 1'b0;
        below <= 1'b1;
        for (int i = 0; i < 300; i++) begin
            @(negedge core_clk);
            check(32'(power_on_pulse), 32'h0000_0000);
        end
        above <= 1'b1;
        below <= 1'b0;
        wait_n(20);
        check(32'(power_on_pulse), 32'h0000_0000);
        above <= 1'b0;
        below <= 1'b1;
        wait_n(DIP_CYCLES - 10);
        check(32'(power_on_pulse), 32'h0000_0000);
        wait_n(25);
        check(32'(power_on_pulse), 32'h0000_0001);
        above <= 1'b1;
        below <= 1'b0;
        wait_n(HOLD_CYCLES + 15);
        check(32'(power_on_pulse), 32'h0000_0000);
        // Second reset with the narrow bus strap: halves come in pairs.
        rst <= 1'b1;
        strap <= 1'b1;
        wait_n(12);
        rst <= 1'b0;
        wait_n(HOLD_CYCLES + 15);
        r = $urandom;
        wr(10'h308, {16'h0000, r[15:0]});
        wr(10'h30A, {16'h0000, r[31:16]});
        rd(10'h308, {16'h0000, r[15:0]});
        rd(10'h30A, {16'h0000, r[31:16]});
        rd(10'h000, 32'h0000_0020);
        rd(10'h002, 32'h0000_0100);
        wait_n(10);
        check(32'(expq.size()), 32'h0000_0000);
        wrap_up();
    end
endmodule
